// ---- verilog/count_channel.sv ----
// One timer channel running modes one to five
module count_channel
   import timer_pkg::*;
#(
   parameter int unsigned CNT_W = COUNT_W
) (
   input  wire logic             core_clk,
   input  wire logic             rst,
   input  wire logic             clk_en,
   input  wire logic             control_word_wr,
   input  wire logic [2:0]       control_word_mode,
   input  wire logic             count_wr,
   input  wire logic [CNT_W-1:0] count_data,
   input  wire logic             chan_clk_pin,
   input  wire logic             gate_pin,
   output logic                  timer_out,
   output logic                  count_busy
);

   // ----------------------------------------------------------------------
   // Elaboration check
   // ----------------------------------------------------------------------
   if (CNT_W < 2) begin : g_chk
      $error("count width must be at least two bits");
   end

   // ----------------------------------------------------------------------
   // Pin synchronisation and event detection
   // ----------------------------------------------------------------------
   pin_if      pins ();
   logic [1:0] levels;

   sync2 #(.WIDTH(2)) u_sync (
      .core_clk  (core_clk),
      .rst       (rst),
      .clk_en    (clk_en),
      .pin_in    ({chan_clk_pin, gate_pin}),
      .level_out (levels)
   );

   // Synchronised levels into the shared bundle
   assign pins.chan_level = levels[1];
   assign pins.gate_level = levels[0];

   pulse_edge u_edge (
      .core_clk (core_clk),
      .rst      (rst),
      .clk_en   (clk_en),
      .pins     (pins)
   );

   // ----------------------------------------------------------------------
   // Channel state
   // ----------------------------------------------------------------------
   typedef struct packed {
      mode_e            mode;
      logic [CNT_W-1:0] count_register;
      logic [CNT_W-1:0] count_elem;
      logic             out;
      logic             armed;
      logic             running;
      logic             load_req;
      logic             trig;
      logic             strobe;
      logic             late;
   } chan_s;

   chan_s s;
   chan_s next_s;
   logic  tick;
   logic  gate;
   logic  start;
   logic  cnt_en;

   assign tick = pins.tick;
   assign gate = pins.gate_level;

   // Even part of the held count, used by square mode
   function automatic logic [CNT_W-1:0] even_of(input logic [CNT_W-1:0] v);
      even_of = {v[CNT_W-1:1], 1'b0};
   endfunction : even_of

   // Load source for the strobe modes
   always_comb begin
      start  = 1'b0;
      cnt_en = 1'b1;
      if (s.mode == MODE_STROBE_SW) begin
         start  = s.load_req;
         cnt_en = gate;
      end else begin
         start  = s.trig & s.armed;
      end
   end

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      next_s = s;
      if (tick) begin
         next_s.trig = 1'b0;
         unique case (s.mode)
            MODE_ONESHOT: begin
               if (s.trig && s.armed) begin
                  next_s.count_elem = s.count_register;
                  next_s.out        = 1'b0;
                  next_s.running    = 1'b1;
               end else if (s.running) begin
                  if (s.count_elem == CNT_W'(1)) begin
                     next_s.out     = 1'b1;
                     next_s.running = 1'b0;
                  end else begin
                     next_s.count_elem = s.count_elem - CNT_W'(1);
                  end
               end
            end
            MODE_RATE: begin
               if (s.load_req || (s.trig && s.armed)) begin
                  next_s.count_elem = s.count_register;
                  next_s.out        = 1'b1;
                  next_s.running    = 1'b1;
                  next_s.load_req   = 1'b0;
               end else if (s.running && gate) begin
                  if (s.count_elem == CNT_W'(2)) begin
                     next_s.out        = 1'b0;
                     next_s.count_elem = CNT_W'(1);
                  end else if (s.count_elem == CNT_W'(1)) begin
                     next_s.out        = 1'b1;
                     next_s.count_elem = s.count_register;
                  end else begin
                     next_s.count_elem = s.count_elem - CNT_W'(1);
                  end
               end
            end
            MODE_SQUARE: begin
               if (s.load_req || (s.trig && s.armed)) begin
                  next_s.count_elem = even_of(s.count_register);
                  next_s.out        = 1'b1;
                  next_s.running    = 1'b1;
                  next_s.load_req   = 1'b0;
                  next_s.late       = 1'b0;
               end else if (s.running && gate) begin
                  if (s.late) begin
                     next_s.out        = 1'b0;
                     next_s.late       = 1'b0;
                     next_s.count_elem = even_of(s.count_register);
                  end else if (s.count_elem <= CNT_W'(2)) begin
                     if (s.out && s.count_register[0]) begin
                        next_s.late       = 1'b1;
                        next_s.count_elem = '0;
                     end else begin
                        next_s.out        = ~s.out;
                        next_s.count_elem = even_of(s.count_register);
                     end
                  end else begin
                     next_s.count_elem = s.count_elem - CNT_W'(2);
                  end
               end
            end
            MODE_STROBE_SW, MODE_STROBE_HW: begin
               if (s.strobe) begin
                  next_s.out    = 1'b1;
                  next_s.strobe = 1'b0;
               end
               if (start) begin
                  next_s.count_elem = s.count_register;
                  next_s.running    = 1'b1;
                  next_s.load_req   = 1'b0;
               end else if (s.running && cnt_en) begin
                  if (s.count_elem == CNT_W'(1)) begin
                     next_s.out     = 1'b0;
                     next_s.strobe  = 1'b1;
                     next_s.running = 1'b0;
                  end
                  next_s.count_elem = s.count_elem - CNT_W'(1);
               end
            end
            default: begin
               next_s.out = OUT_RESET;
            end
         endcase
      end
      // Gate low stops periodic modes and lifts the output at once
      if ((s.mode == MODE_RATE || s.mode == MODE_SQUARE) && !gate) begin
         next_s.out = 1'b1;
      end
      // A complete count write; the whole count arrives in one pulse
      if (count_wr) begin
         next_s.count_register = count_data;
         next_s.armed          = 1'b1;
         if (s.mode == MODE_STROBE_SW ||
             ((s.mode == MODE_RATE || s.mode == MODE_SQUARE) && !s.running)) begin
            next_s.load_req = 1'b1;
         end
      end
      // Trigger set wins over the clear of a consumed one
      if (pins.gate_rise) begin
         next_s.trig = 1'b1;
      end
      // Control word rewrites the mode and disarms
      if (control_word_wr) begin
         next_s.mode     = mode_e'(control_word_mode);
         next_s.out      = OUT_RESET;
         next_s.armed    = 1'b0;
         next_s.running  = 1'b0;
         next_s.load_req = 1'b0;
         next_s.trig     = 1'b0;
         next_s.strobe   = 1'b0;
         next_s.late     = 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s      <= '0;
         s.mode <= MODE_IDLE;
         s.out  <= OUT_RESET;
      end else if (clk_en) begin
         s <= next_s;
      end
   end

   assign timer_out  = s.out;
   assign count_busy = s.running;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   sequence s_trig_tick;
      tick && s.trig && s.armed && !control_word_wr && !count_wr;
   endsequence

   property p_os_fall;
      @(posedge core_clk) disable iff (rst)
      (s.mode == MODE_ONESHOT) and s_trig_tick |=> !s.out && s.count_elem == $past(s.count_register);
   endproperty
   a_os_fall: assert property (p_os_fall) else $error("one-shot did not fall on trigger");

   property p_os_gate_free;
      @(posedge core_clk) disable iff (rst)
      (s.mode == MODE_ONESHOT && !tick && !control_word_wr) |=> $stable(s.out);
   endproperty
   a_os_gate_free: assert property (p_os_gate_free) else $error("one-shot output moved off pulse");

   property p_os_retrig;
      @(posedge core_clk) disable iff (rst)
      (s.mode == MODE_ONESHOT && s.running) and s_trig_tick |=> s.running && s.count_elem == $past(s.count_register);
   endproperty
   a_os_retrig: assert property (p_os_retrig) else $error("retrigger did not restart");

   property p_rate_low;
      @(posedge core_clk) disable iff (rst)
      (s.mode == MODE_RATE && tick && s.running && gate && s.count_elem == CNT_W'(2)
       && !s.load_req && !s.trig && !control_word_wr) |=> !s.out && s.count_elem == CNT_W'(1);
   endproperty
   a_rate_low: assert property (p_rate_low) else $error("rate output did not fall at one");

   property p_rate_gate_low;
      @(posedge core_clk) disable iff (rst)
      (s.mode == MODE_RATE && clk_en && !gate && !control_word_wr) |=> s.out;
   endproperty
   a_rate_gate_low: assert property (p_rate_gate_low) else $error("gate low left output low");

   property p_rate_reload;
      @(posedge core_clk) disable iff (rst)
      (s.mode == MODE_RATE) and s_trig_tick |=> s.count_elem == $past(s.count_register) && s.out;
   endproperty
   a_rate_reload: assert property (p_rate_reload) else $error("rate trigger did not reload");

   property p_sq_gate_low;
      @(posedge core_clk) disable iff (rst)
      (s.mode == MODE_SQUARE && clk_en && !gate && !control_word_wr) |=> s.out;
   endproperty
   a_sq_gate_low: assert property (p_sq_gate_low) else $error("square gate low left output low");

   property p_sw_load;
      @(posedge core_clk) disable iff (rst)
      (s.mode == MODE_STROBE_SW && tick && s.load_req && !control_word_wr && !count_wr)
      |=> s.count_elem == $past(s.count_register) && s.running;
   endproperty
   a_sw_load: assert property (p_sw_load) else $error("load pulse decremented");

   property p_strobe_one;
      @(posedge core_clk) disable iff (rst)
      ((s.mode == MODE_STROBE_SW || s.mode == MODE_STROBE_HW) && tick && s.strobe
       && !control_word_wr) |=> s.out;
   endproperty
   a_strobe_one: assert property (p_strobe_one) else $error("strobe longer than one pulse");

   property p_hw_trig;
      @(posedge core_clk) disable iff (rst)
      (s.mode == MODE_STROBE_HW) and s_trig_tick |=> s.count_elem == $past(s.count_register);
   endproperty
   a_hw_trig: assert property (p_hw_trig) else $error("hardware trigger did not load");

endmodule : count_channel

// ---- verilog/timer_pkg.sv ----
package timer_pkg;

   // ----------------------------------------------------------------------
   // Sizes and reset values
   // ----------------------------------------------------------------------
   localparam int unsigned COUNT_W   = 16;
   localparam int unsigned SYNC_W    = 2;
   localparam logic        OUT_RESET = 1'b1;
   localparam logic [1:0]  SYNC_IDLE = 2'h0;

   // ----------------------------------------------------------------------
   // Counting modes
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      MODE_IDLE      = 3'b000,
      MODE_ONESHOT   = 3'b001,
      MODE_RATE      = 3'b010,
      MODE_SQUARE    = 3'b011,
      MODE_STROBE_SW = 3'b100,
      MODE_STROBE_HW = 3'b101
   } mode_e;

endpackage : timer_pkg

// ---- verilog/pin_if.sv ----
// Synchronised pin levels and the events derived from them
interface pin_if;
   logic chan_level;
   logic gate_level;
   logic tick;
   logic gate_rise;

   modport edge_src (input chan_level, input gate_level, output tick, output gate_rise);
   modport core     (input gate_level, input tick, input gate_rise);
endinterface : pin_if

// ---- verilog/sync2.sv ----
// Two-stage synchroniser for asynchronous pins
module sync2
   import timer_pkg::*;
#(
   parameter int unsigned WIDTH = SYNC_W
) (
   input  wire logic             core_clk,
   input  wire logic             rst,
   input  wire logic             clk_en,
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] level_out
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } sync_s;

   sync_s s;
   sync_s next_s;

   if (WIDTH < 1) begin : g_chk
      $error("sync2 needs at least one bit");
   end

   // Second stage reads the first, nothing else does
   always_comb begin
      next_s        = s;
      next_s.meta   = pin_in;
      next_s.stable = s.meta;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s <= '0;
      end else if (clk_en) begin
         s <= next_s;
      end
   end

   assign level_out = s.stable;

endmodule : sync2

// ---- verilog/pulse_edge.sv ----
// Clock pulse and trigger detection on synchronised levels
module pulse_edge
   import timer_pkg::*;
(
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic clk_en,
   pin_if.edge_src   pins
);

   typedef struct packed {
      logic chan_prev;
      logic chan_seen_high;
      logic gate_prev;
   } edge_s;

   edge_s s;
   edge_s next_s;

   // Previous levels; a pulse needs a high seen before the fall
   always_comb begin
      next_s           = s;
      next_s.chan_prev = pins.chan_level;
      next_s.gate_prev = pins.gate_level;
      if (pins.chan_level) begin
         next_s.chan_seen_high = 1'b1;
      end else if (s.chan_prev) begin
         next_s.chan_seen_high = 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s <= '0;
      end else if (clk_en) begin
         s <= next_s;
      end
   end

   // Complete pulse ends on the falling edge
   assign pins.tick      = clk_en & s.chan_seen_high & s.chan_prev & ~pins.chan_level;
   assign pins.gate_rise = clk_en & ~s.gate_prev & pins.gate_level;

   property p_tick_fall;
      @(posedge core_clk) disable iff (rst)
      (pins.tick && $past(clk_en)) |-> ($past(pins.chan_level) && !pins.chan_level);
   endproperty
   a_tick_fall: assert property (p_tick_fall) else $error("tick without clock fall");

endmodule : pulse_edge

// ---- sim/host_model.sv ----
// Host processor and pin environment driving one timer channel
module host_model
   import timer_pkg::*;
(
   input  wire logic               core_clk,
   output logic                    control_word_wr,
   output logic [2:0]              control_word_mode,
   output logic                    count_wr,
   output logic [COUNT_W-1:0]      count_data,
   output logic                    chan_clk_pin,
   output logic                    gate_pin
);
   timeunit 1ns;
   timeprecision 100ps;

   // ----------------------------------------------------------------------
   // Channel clock pin
   // ----------------------------------------------------------------------
   localparam int CHAN_HALF = 6;
   int   phase = 0;
   logic [2:0] cur_mode = 3'h0;

   // Channel clock: six core cycles high, six low
   always @(posedge core_clk) begin
      phase <= (phase == 2 * CHAN_HALF - 1) ? 0 : phase + 1;
      chan_clk_pin <= #1 (phase < CHAN_HALF);
   end

   initial begin
      control_word_wr   = 1'b0;
      control_word_mode = 3'h0;
      count_wr          = 1'b0;
      count_data        = '0;
      chan_clk_pin      = 1'b0;
      gate_pin          = 1'b0;
   end

   // ----------------------------------------------------------------------
   // Host writes, each one request held for one edge
   // ----------------------------------------------------------------------
   task write_cw(input logic [2:0] mode);
      @(posedge core_clk);
      #1 control_word_wr = 1'b1;
      control_word_mode = mode;
      cur_mode = mode;
      @(posedge core_clk);
      #1 control_word_wr = 1'b0;
   endtask : write_cw

   // Whole count in one pulse; never a count of one in rate mode
   task write_count(input logic [COUNT_W-1:0] value);
      if (cur_mode == MODE_RATE && value == 16'h0001) return;
      @(posedge core_clk);
      #1 count_wr = 1'b1;
      count_data = value;
      @(posedge core_clk);
      #1 count_wr = 1'b0;
   endtask : write_count

   // Gate moves just after the next core clock edge, at any phase of the channel clock
   task set_gate(input logic level);
      @(posedge core_clk);
      #1 gate_pin = level;
   endtask : set_gate
endmodule : host_model

// ---- sim/tb_top.sv ----
// Self-checking bench for one timer channel in modes one to five
module tb_top
   import timer_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   // ----------------------------------------------------------------------
   // Clock, reset and wiring
   // ----------------------------------------------------------------------
   localparam int LIMIT = 20000;
   logic               core_clk = 1'b0;
   logic               rst      = 1'b1;
   logic               clk_en   = 1'b1;
   logic               control_word_wr;
   logic [2:0]         control_word_mode;
   logic               count_wr;
   logic [COUNT_W-1:0] count_data;
   logic               chan_clk_pin;
   logic               gate_pin;
   logic               timer_out;
   logic               count_busy;
   int                 n_fail      = 0;
   int                 checks_done = 0;
   int                 cycles      = 0;

   // Free-running core clock
   always #5 core_clk = ~core_clk;

   host_model host (
      .core_clk          (core_clk),
      .control_word_wr   (control_word_wr),
      .control_word_mode (control_word_mode),
      .count_wr          (count_wr),
      .count_data        (count_data),
      .chan_clk_pin      (chan_clk_pin),
      .gate_pin          (gate_pin)
   );

   count_channel uut (
      .core_clk          (core_clk),
      .rst               (rst),
      .clk_en            (clk_en),
      .control_word_wr   (control_word_wr),
      .control_word_mode (control_word_mode),
      .count_wr          (count_wr),
      .count_data        (count_data),
      .chan_clk_pin      (chan_clk_pin),
      .gate_pin          (gate_pin),
      .timer_out         (timer_out),
      .count_busy        (count_busy)
   );

   // ----------------------------------------------------------------------
   // Shared helpers
   // ----------------------------------------------------------------------
   task results;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : results

   task chk(input string what, input logic exp, input logic got);
      checks_done++;
      if (got !== exp) begin
         $display("[ERR] %s expected %b seen %b", what, exp, got);
         n_fail++;
      end
   endtask : chk

   // Wait n channel pulses, then until the output has settled
   task pulses(input int n);
      repeat (n) @(negedge chan_clk_pin);
      repeat (5) @(posedge core_clk);
      #1;
   endtask : pulses

   task run_chk(input int n, input logic exp, input string what);
      pulses(n);
      chk(what, exp, timer_out);
   endtask : run_chk

   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   task t_reset;
      chk("out after reset", 1'b1, timer_out);
      chk("busy after reset", 1'b0, count_busy);
   endtask : t_reset

   task t_strobe_sw;
      host.set_gate(1'b1);
      host.write_cw(MODE_STROBE_SW);
      host.write_count(16'h0003);
      run_chk(1, 1'b1, "sw strobe load");
      chk("busy counting", 1'b1, count_busy);
      run_chk(2, 1'b1, "sw strobe before expiry");
      run_chk(1, 1'b0, "sw strobe low");
      run_chk(1, 1'b1, "sw strobe back high");
      host.write_count(16'h0003);
      pulses(2);
      host.write_count(16'h0002);
      run_chk(2, 1'b1, "sw rewrite pending");
      run_chk(1, 1'b0, "sw rewrite strobe");
   endtask : t_strobe_sw

   task t_oneshot;
      host.set_gate(1'b0);
      host.write_cw(MODE_ONESHOT);
      host.write_count(16'h0003);
      run_chk(2, 1'b1, "one-shot armed only");
      host.set_gate(1'b1);
      host.set_gate(1'b0);
      run_chk(1, 1'b0, "one-shot start");
      run_chk(1, 1'b0, "one-shot held");
      host.write_count(16'h0005);
      run_chk(1, 1'b0, "one-shot still low");
      run_chk(1, 1'b1, "one-shot end");
      run_chk(2, 1'b1, "one-shot rests high");
      host.set_gate(1'b1);
      host.set_gate(1'b0);
      run_chk(4, 1'b0, "one-shot new count");
      host.set_gate(1'b1);
      host.set_gate(1'b0);
      run_chk(5, 1'b0, "one-shot retriggered");
      run_chk(1, 1'b1, "one-shot retrigger end");
   endtask : t_oneshot

   task t_rate;
      host.set_gate(1'b1);
      host.write_cw(MODE_RATE);
      host.write_count(16'h0001);
      host.write_count(16'h0004);
      run_chk(3, 1'b1, "rate before first low");
      run_chk(1, 1'b0, "rate low at one");
      run_chk(1, 1'b1, "rate back high");
      host.write_count(16'h0006);
      run_chk(2, 1'b1, "rate period undisturbed");
      run_chk(1, 1'b0, "rate old period end");
      run_chk(5, 1'b1, "rate new period high");
      run_chk(1, 1'b0, "rate new period low");
      host.set_gate(1'b0);
      repeat (5) @(posedge core_clk);
      #1 chk("rate gate low forces high", 1'b1, timer_out);
      run_chk(8, 1'b1, "rate gate low stops");
      host.set_gate(1'b1);
      run_chk(5, 1'b1, "rate after trigger");
      run_chk(1, 1'b0, "rate trigger sync low");
   endtask : t_rate

   task t_square;
      host.write_cw(MODE_SQUARE);
      host.write_count(16'h0004);
      run_chk(2, 1'b1, "square even high");
      run_chk(1, 1'b0, "square even toggles low");
      run_chk(1, 1'b0, "square even low half");
      run_chk(1, 1'b1, "square even toggles high");
      host.write_cw(MODE_SQUARE);
      host.write_count(16'h0005);
      run_chk(3, 1'b1, "square odd high");
      run_chk(1, 1'b0, "square odd low");
      run_chk(1, 1'b0, "square odd low half");
      run_chk(1, 1'b1, "square odd back high");
   endtask : t_square

   task t_strobe_hw;
      host.set_gate(1'b0);
      host.write_cw(MODE_STROBE_HW);
      host.write_count(16'h0002);
      run_chk(3, 1'b1, "hw strobe waits trigger");
      host.set_gate(1'b1);
      run_chk(1, 1'b1, "hw strobe load");
      host.write_count(16'h0004);
      run_chk(1, 1'b1, "hw strobe counting");
      run_chk(1, 1'b0, "hw strobe old count low");
      run_chk(1, 1'b1, "hw strobe high again");
      host.set_gate(1'b0);
      pulses(1);
      host.set_gate(1'b1);
      run_chk(4, 1'b1, "hw strobe new count");
      run_chk(1, 1'b0, "hw strobe new low");
   endtask : t_strobe_hw

   // Clock enable freezes a pending strobe; reset mid-count clears it
   task t_freeze_reset;
      clk_en = 1'b0;
      pulses(2);
      chk("frozen strobe", 1'b0, timer_out);
      clk_en = 1'b1;
      run_chk(1, 1'b1, "strobe after thaw");
      host.set_gate(1'b0);
      host.set_gate(1'b1);
      pulses(2);
      chk("busy before reset", 1'b1, count_busy);
      rst = 1'b1;
      #1 chk("out in reset", 1'b1, timer_out);
      chk("busy in reset", 1'b0, count_busy);
      repeat (4) @(posedge core_clk);
      #1 rst = 1'b0;
      run_chk(3, 1'b1, "no strobe after reset");
      chk("idle after reset", 1'b0, count_busy);
   endtask : t_freeze_reset

   // ----------------------------------------------------------------------
   // Main sequence and hang guard
   // ----------------------------------------------------------------------
   initial begin
      repeat (4) @(posedge core_clk);
      #1 rst = 1'b0;
      pulses(1);
      t_reset();
      t_strobe_sw();
      t_oneshot();
      t_rate();
      t_square();
      t_strobe_hw();
      t_freeze_reset();
      results();
   end

   // Cycle ceiling for the whole run
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         n_fail++;
         results();
      end
   end
endmodule : tb_top
